// File: hdl/adcseq_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef ADCSEQ_REGS_SVH
`define ADCSEQ_REGS_SVH

`define ADCSEQ_ADDR_W          10
`define ADCSEQ_IDX_W           8

// register indices; the byte address is four times the index
`define ADCSEQ_IDX_CTRL        8'hB4
`define ADCSEQ_IDX_SEQ         8'hB5
`define ADCSEQ_IDX_EXTRA       8'hB6
`define ADCSEQ_IDX_AINEN       8'hB7
`define ADCSEQ_IDX_RESLO       8'hBA
`define ADCSEQ_IDX_RESHI       8'hBB

// converter_control_one fields
`define ADCSEQ_CTRL_EOC_BIT    7
`define ADCSEQ_CTRL_ST_BIT     6
`define ADCSEQ_CTRL_SRC_MSB    5
`define ADCSEQ_CTRL_SRC_LSB    4
`define ADCSEQ_CTRL_RSV_MSB    1
`define ADCSEQ_CTRL_RSV_LSB    0

// sequence and extra configuration fields (same layout)
`define ADCSEQ_CFG_REF_MSB     7
`define ADCSEQ_CFG_REF_LSB     6
`define ADCSEQ_CFG_DEC_MSB     5
`define ADCSEQ_CFG_DEC_LSB     4
`define ADCSEQ_CFG_CH_MSB      3
`define ADCSEQ_CFG_CH_LSB      0

// result byte layout
`define ADCSEQ_RES_W           14
`define ADCSEQ_RESLO_PAD       2'h0

// reset values
`define ADCSEQ_RST_SRC         2'h3
`define ADCSEQ_RST_RSV         2'h3
`define ADCSEQ_RST_SEQ         8'h10
`define ADCSEQ_RST_EXTRA       8'h00
`define ADCSEQ_RST_AINEN       8'h00
`define ADCSEQ_RST_RESULT      14'h0000

// timing
`define ADCSEQ_SYS_CLK_KHZ     200000
`define ADCSEQ_CONV_CLK_KHZ    4000
`define ADCSEQ_DIV_CYCLES      (`ADCSEQ_SYS_CLK_KHZ / `ADCSEQ_CONV_CLK_KHZ)
`define ADCSEQ_SETTLE_TICKS    10'd16
`define ADCSEQ_DEC_BASE        10'd64

// bus answers
`define ADCSEQ_RESP_OKAY       2'h0
`define ADCSEQ_RESP_SLVERR     2'h2

`endif

// File: hdl/adcseq_pkg.sv
// types shared by the conversion sequencer
package adcseq_pkg;

	typedef enum logic [1:0] {
		ADCSEQ_SRC_EXT   = 2'b00,
		ADCSEQ_SRC_FULL  = 2'b01,
		ADCSEQ_SRC_TIMER = 2'b10,
		ADCSEQ_SRC_STBIT = 2'b11
	} adcseq_src_t;

	typedef enum logic [0:0] {
		ADCSEQ_IDLE = 1'b0,
		ADCSEQ_CONV = 1'b1
	} adcseq_state_t;

	typedef logic [3:0] adcseq_chan_t;

endpackage

// File: hdl/adcseq_top.sv
// conversion sequencer with axi4-lite register slave
// Operation
// - end flag sets on finish, clears on high byte read
// - flag stays high over unread results
// - start bit starts sequence in mode 11
// - start bit reads one while sequence runs
// - start source select picks start event
// - last channel field ends the sequence
// - extra register write starts extra conversion
// - extra fields coded like sequence fields
// - results in two's complement
// - low byte bits 7:2, high byte 13:6
// - channel field reads result's channel
// - conversion clock is system clock over fifty
// - filter takes decimation-rate conversion periods
// - sixteen settling periods precede filtering
// - interrupt only on extra conversion finish
// - dma trigger only on sequence conversions
// - per-channel dma trigger for channels 0-7
// - any-channel dma trigger on sequence data
// - sequence range from last channel value
// - channel codes map inputs, pairs, internals
// - decimation codes 64, 128, 256, 512
// - disabled inputs skipped in sequence
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "adcseq_regs.svh"

module adcseq_top
	import adcseq_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic [`ADCSEQ_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [`ADCSEQ_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       externalTriggerPin,
	input  wire logic                       timerCompareEvent,
	input  wire logic [`ADCSEQ_RES_W-1:0]   convResult,
	output logic                            convTick,
	output logic                            convActive,
	output logic [3:0]                      convChannel,
	output logic [1:0]                      convReference,
	output logic [1:0]                      convDecimation,
	output logic                            extraDoneIrq,
	output logic [7:0]                      perChannelDmaTrigger,
	output logic                            anyChannelDmaTrigger
);

	localparam int DIV_CYCLES = `ADCSEQ_DIV_CYCLES;
	localparam logic [7:0] DIV_LAST = 8'(DIV_CYCLES - 1);

	// channel enable per input or differential pair; internals always on
	function automatic logic chanOn(
		input logic [3:0] c,
		input logic [7:0] en
	);
		logic on;
		if (c < 4'h8) begin
			on = en[c[2:0]];
		end else if (c < 4'hC) begin
			on = en[{c[1:0], 1'b0}] & en[{c[1:0], 1'b1}];
		end else begin
			on = 1'b1;
		end
		return on;
	endfunction

	// lowest enabled channel in [from, last]; bit 4 flags a hit
	function automatic logic [4:0] nextChan(
		input logic [4:0] from,
		input logic [3:0] last,
		input logic [7:0] en
	);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (5'(i) >= from && 4'(i) <= last && chanOn(4'(i), en)) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// bus state
	logic                       awHave;
	logic                       next_awHave;
	logic [`ADCSEQ_IDX_W-1:0]   awIdx;
	logic [`ADCSEQ_IDX_W-1:0]   next_awIdx;
	logic                       wHave;
	logic                       next_wHave;
	logic [7:0]                 wData;
	logic [7:0]                 next_wData;
	logic                       wLane;
	logic                       next_wLane;
	logic                       next_awready;
	logic                       next_wready;
	logic [1:0]                 next_bresp;
	logic                       next_bvalid;
	logic                       next_arready;
	logic [31:0]                next_rdata;
	logic [1:0]                 next_rresp;
	logic                       next_rvalid;

	// registers
	logic [1:0]                 startSource;
	logic [1:0]                 next_startSource;
	logic [1:0]                 ctrlReserved;
	logic [1:0]                 next_ctrlReserved;
	logic [1:0]                 seqRef;
	logic [1:0]                 next_seqRef;
	logic [1:0]                 seqDec;
	logic [1:0]                 next_seqDec;
	adcseq_chan_t               seqLast;
	adcseq_chan_t               next_seqLast;
	logic [1:0]                 extraRef;
	logic [1:0]                 next_extraRef;
	logic [1:0]                 extraDec;
	logic [1:0]                 next_extraDec;
	adcseq_chan_t               extraChan;
	adcseq_chan_t               next_extraChan;
	logic [7:0]                 ainEnable;
	logic [7:0]                 next_ainEnable;
	logic [`ADCSEQ_RES_W-1:0]   result;
	logic [`ADCSEQ_RES_W-1:0]   next_result;
	adcseq_chan_t               resultChan;
	adcseq_chan_t               next_resultChan;
	logic                       eoc;
	logic                       next_eoc;

	// sequencer state
	adcseq_state_t              state;
	adcseq_state_t              next_state;
	logic                       seqActive;
	logic                       next_seqActive;
	logic                       isExtra;
	logic                       next_isExtra;
	logic                       extraPending;
	logic                       next_extraPending;
	logic                       extPrev;
	logic [7:0]                 divCnt;
	logic [7:0]                 next_divCnt;
	logic                       next_convTick;
	logic [9:0]                 phase;
	logic [9:0]                 next_phase;
	logic                       next_convActive;
	logic [3:0]                 next_convChannel;
	logic [1:0]                 next_convReference;
	logic [1:0]                 next_convDecimation;
	logic                       next_extraDoneIrq;
	logic                       next_anyDma;

	// combinational helpers
	logic                       wrFire;
	logic                       wrMapped;
	logic                       rdFire;
	logic [`ADCSEQ_IDX_W-1:0]   arIdx;
	logic                       stWrite;
	logic                       extraWrite;
	logic                       startEvent;
	logic                       finish;
	logic [9:0]                 lastPhase;
	logic [4:0]                 firstChan;
	logic [4:0]                 seqHit;
	logic [4:0]                 nextHit;
	logic [7:0]                 dmaHit;

	assign arIdx = s_axi_araddr[`ADCSEQ_ADDR_W-1:2];
	assign rdFire = s_axi_arvalid && s_axi_arready;
	assign wrFire = awHave && wHave && !s_axi_bvalid;
	assign wrMapped = awIdx == `ADCSEQ_IDX_CTRL || awIdx == `ADCSEQ_IDX_SEQ
		|| awIdx == `ADCSEQ_IDX_EXTRA || awIdx == `ADCSEQ_IDX_AINEN
		|| awIdx == `ADCSEQ_IDX_RESLO || awIdx == `ADCSEQ_IDX_RESHI;
	// settle then decimate; rate is 64 shifted by the 2-bit code
	assign lastPhase = `ADCSEQ_SETTLE_TICKS
		+ (`ADCSEQ_DEC_BASE << convDecimation) - 10'd1;
	assign finish = state == ADCSEQ_CONV && convTick && phase == lastPhase;
	assign firstChan = (seqLast < 4'h8) ? 5'h00
		: (seqLast <= 4'hC) ? 5'h08 : {1'b0, seqLast};
	assign seqHit = nextChan(firstChan, seqLast, ainEnable);
	assign nextHit = nextChan({1'b0, convChannel} + 5'h01, seqLast,
		ainEnable);

	generate
		for (genvar g = 0; g < 8; g++) begin : gDma
			assign dmaHit[g] = finish && !isExtra && convChannel == 4'(g);
		end
	endgenerate

	always_comb begin
		startEvent = 1'b0;
		case (adcseq_src_t'(startSource))
			ADCSEQ_SRC_EXT:   startEvent = externalTriggerPin && !extPrev;
			ADCSEQ_SRC_FULL:  startEvent = 1'b1;
			ADCSEQ_SRC_TIMER: startEvent = timerCompareEvent;
			ADCSEQ_SRC_STBIT: startEvent = stWrite;
			default:          startEvent = 1'b0;
		endcase
	end

	always_comb begin
		next_awHave = awHave;
		next_awIdx = awIdx;
		next_wHave = wHave;
		next_wData = wData;
		next_wLane = wLane;
		next_bresp = s_axi_bresp;
		next_bvalid = s_axi_bvalid;
		next_arready = s_axi_arready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_rvalid = s_axi_rvalid;
		next_startSource = startSource;
		next_ctrlReserved = ctrlReserved;
		next_seqRef = seqRef;
		next_seqDec = seqDec;
		next_seqLast = seqLast;
		next_extraRef = extraRef;
		next_extraDec = extraDec;
		next_extraChan = extraChan;
		next_ainEnable = ainEnable;
		stWrite = 1'b0;
		extraWrite = 1'b0;

		// write side: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHave = 1'b1;
			next_awIdx = s_axi_awaddr[`ADCSEQ_ADDR_W-1:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHave = 1'b1;
			next_wData = s_axi_wdata[7:0];
			next_wLane = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wrFire) begin
			next_awHave = 1'b0;
			next_wHave = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wrMapped ? `ADCSEQ_RESP_OKAY : `ADCSEQ_RESP_SLVERR;
			if (wLane) begin
				case (awIdx)
					`ADCSEQ_IDX_CTRL: begin
						next_startSource = wData[`ADCSEQ_CTRL_SRC_MSB:
							`ADCSEQ_CTRL_SRC_LSB];
						next_ctrlReserved = wData[`ADCSEQ_CTRL_RSV_MSB:
							`ADCSEQ_CTRL_RSV_LSB];
						stWrite = wData[`ADCSEQ_CTRL_ST_BIT]
							&& startSource == ADCSEQ_SRC_STBIT;
					end
					`ADCSEQ_IDX_SEQ: begin
						next_seqRef = wData[`ADCSEQ_CFG_REF_MSB:
							`ADCSEQ_CFG_REF_LSB];
						next_seqDec = wData[`ADCSEQ_CFG_DEC_MSB:
							`ADCSEQ_CFG_DEC_LSB];
						next_seqLast = wData[`ADCSEQ_CFG_CH_MSB:
							`ADCSEQ_CFG_CH_LSB];
					end
					`ADCSEQ_IDX_EXTRA: begin
						next_extraRef = wData[`ADCSEQ_CFG_REF_MSB:
							`ADCSEQ_CFG_REF_LSB];
						next_extraDec = wData[`ADCSEQ_CFG_DEC_MSB:
							`ADCSEQ_CFG_DEC_LSB];
						next_extraChan = wData[`ADCSEQ_CFG_CH_MSB:
							`ADCSEQ_CFG_CH_LSB];
						extraWrite = 1'b1;
					end
					`ADCSEQ_IDX_AINEN: begin
						next_ainEnable = wData;
					end
					default: begin
					end
				endcase
			end
		end
		// no new address while a response is owed
		next_awready = !next_awHave && !next_bvalid;
		next_wready = !next_wHave && !next_bvalid;

		// read side
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (rdFire) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `ADCSEQ_RESP_OKAY;
			case (arIdx)
				`ADCSEQ_IDX_CTRL:
					next_rdata = {24'h000000, eoc, seqActive, startSource,
						2'h0, ctrlReserved};
				`ADCSEQ_IDX_SEQ:
					next_rdata = {24'h000000, seqRef, seqDec,
						resultChan};
				`ADCSEQ_IDX_EXTRA:
					next_rdata = {24'h000000, extraRef, extraDec, extraChan};
				`ADCSEQ_IDX_AINEN:
					next_rdata = {24'h000000, ainEnable};
				`ADCSEQ_IDX_RESLO:
					next_rdata = {24'h000000, result[5:0],
						`ADCSEQ_RESLO_PAD};
				`ADCSEQ_IDX_RESHI:
					next_rdata = {24'h000000, result[13:6]};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `ADCSEQ_RESP_SLVERR;
				end
			endcase
		end
	end

	always_comb begin
		next_state = state;
		next_seqActive = seqActive;
		next_isExtra = isExtra;
		next_extraPending = extraPending;
		next_phase = phase;
		next_convActive = convActive;
		next_convChannel = convChannel;
		next_convReference = convReference;
		next_convDecimation = convDecimation;
		next_result = result;
		next_resultChan = resultChan;
		next_eoc = eoc;
		next_extraDoneIrq = 1'b0;
		next_anyDma = 1'b0;

		// divider: one 4 MHz enable every DIV_CYCLES clocks
		if (divCnt == DIV_LAST) begin
			next_divCnt = 8'h00;
			next_convTick = 1'b1;
		end else begin
			next_divCnt = divCnt + 8'h01;
			next_convTick = 1'b0;
		end

		// high byte read ends the result; a same-cycle finish wins below
		if (rdFire && arIdx == `ADCSEQ_IDX_RESHI) begin
			next_eoc = 1'b0;
		end

		case (state)
			ADCSEQ_IDLE: begin
				// a pending extra goes ahead of any new sequence
				if (extraPending) begin
					next_state = ADCSEQ_CONV;
					next_isExtra = 1'b1;
					next_extraPending = 1'b0;
					next_phase = 10'h000;
					next_convActive = 1'b1;
					next_convChannel = extraChan;
					next_convReference = extraRef;
					next_convDecimation = extraDec;
				end else if (startEvent && seqHit[4]) begin
					next_state = ADCSEQ_CONV;
					next_seqActive = 1'b1;
					next_isExtra = 1'b0;
					next_phase = 10'h000;
					next_convActive = 1'b1;
					next_convChannel = seqHit[3:0];
					next_convReference = seqRef;
					next_convDecimation = seqDec;
				end
			end
			ADCSEQ_CONV: begin
				// start events are not queued while busy
				if (convTick) begin
					next_phase = phase + 10'h001;
				end
				if (finish) begin
					next_phase = 10'h000;
					next_result = convResult;
					next_resultChan = convChannel;
					next_eoc = 1'b1;
					if (isExtra) begin
						next_extraDoneIrq = 1'b1;
						next_state = ADCSEQ_IDLE;
						next_convActive = 1'b0;
						next_isExtra = 1'b0;
					end else begin
						next_anyDma = 1'b1;
						if (nextHit[4]) begin
							next_convChannel = nextHit[3:0];
							next_convReference = seqRef;
							next_convDecimation = seqDec;
						end else begin
							next_state = ADCSEQ_IDLE;
							next_seqActive = 1'b0;
							next_convActive = 1'b0;
						end
					end
				end
			end
			default: begin
				next_state = ADCSEQ_IDLE;
			end
		endcase

		// written while busy, the extra waits for the current work
		if (extraWrite) begin
			next_extraPending = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			awHave <= 1'b0;
			awIdx <= '0;
			wHave <= 1'b0;
			wData <= 8'h00;
			wLane <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bresp <= `ADCSEQ_RESP_OKAY;
			s_axi_bvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ADCSEQ_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			startSource <= `ADCSEQ_RST_SRC;
			ctrlReserved <= `ADCSEQ_RST_RSV;
			{seqRef, seqDec, seqLast} <= `ADCSEQ_RST_SEQ;
			{extraRef, extraDec, extraChan} <= `ADCSEQ_RST_EXTRA;
			ainEnable <= `ADCSEQ_RST_AINEN;
			result <= `ADCSEQ_RST_RESULT;
			resultChan <= 4'h0;
			eoc <= 1'b0;
			state <= ADCSEQ_IDLE;
			seqActive <= 1'b0;
			isExtra <= 1'b0;
			extraPending <= 1'b0;
			extPrev <= 1'b0;
			divCnt <= 8'h00;
			convTick <= 1'b0;
			phase <= 10'h000;
			convActive <= 1'b0;
			convChannel <= 4'h0;
			convReference <= 2'h0;
			convDecimation <= 2'h0;
			extraDoneIrq <= 1'b0;
			perChannelDmaTrigger <= 8'h00;
			anyChannelDmaTrigger <= 1'b0;
		end else begin
			awHave <= next_awHave;
			awIdx <= next_awIdx;
			wHave <= next_wHave;
			wData <= next_wData;
			wLane <= next_wLane;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bresp <= next_bresp;
			s_axi_bvalid <= next_bvalid;
			s_axi_arready <= next_arready || (!s_axi_arready
				&& !s_axi_rvalid && !next_rvalid);
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			s_axi_rvalid <= next_rvalid;
			startSource <= next_startSource;
			ctrlReserved <= next_ctrlReserved;
			seqRef <= next_seqRef;
			seqDec <= next_seqDec;
			seqLast <= next_seqLast;
			extraRef <= next_extraRef;
			extraDec <= next_extraDec;
			extraChan <= next_extraChan;
			ainEnable <= next_ainEnable;
			result <= next_result;
			resultChan <= next_resultChan;
			eoc <= next_eoc;
			state <= next_state;
			seqActive <= next_seqActive;
			isExtra <= next_isExtra;
			extraPending <= next_extraPending;
			extPrev <= externalTriggerPin;
			divCnt <= next_divCnt;
			convTick <= next_convTick;
			phase <= next_phase;
			convActive <= next_convActive;
			convChannel <= next_convChannel;
			convReference <= next_convReference;
			convDecimation <= next_convDecimation;
			extraDoneIrq <= next_extraDoneIrq;
			perChannelDmaTrigger <= dmaHit;
			anyChannelDmaTrigger <= next_anyDma;
		end
	end

endmodule

// File: sim/adcseq_chk.sv
// concurrent checks on conversion timing and trigger outputs
`timescale 1ns/100ps
`include "adcseq_regs.svh"
module adcseq_chk (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       convTick,
	input wire logic       convActive,
	input wire logic [3:0] convChannel,
	input wire logic [1:0] convDecimation,
	input wire logic       extraDoneIrq,
	input wire logic [7:0] perChannelDmaTrigger,
	input wire logic       anyChannelDmaTrigger
);
	logic [5:0] gap;
	logic       gapOk;
	logic [9:0] ticks;
	logic       done;
	assign done = anyChannelDmaTrigger | extraDoneIrq;
	// first tick after reset has no reference point
	always_ff @(posedge clk) begin
		gap   <= (srst || convTick) ? 6'h00 : gap + 6'h01;
		gapOk <= !srst && (gapOk || convTick);
	end
	// a done cycle also starts the next conversion
	always_ff @(posedge clk) begin
		if (srst || !convActive || done) begin
			ticks <= 10'h000;
		end else if (convTick) begin
			ticks <= ticks + 10'h001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_gap;
		convTick && gapOk |-> gap == `ADCSEQ_DIV_CYCLES - 1;
	endproperty
	a_gap: assert property (p_gap) else $error("tick gap");
	property p_len;
		done |-> ticks ==
			`ADCSEQ_SETTLE_TICKS + (`ADCSEQ_DEC_BASE << $past(convDecimation));
	endproperty
	a_len: assert property (p_len)
		else $error("conv length");
	property p_chan;
		anyChannelDmaTrigger |-> perChannelDmaTrigger == ($past(convChannel)
			< 4'h8 ? 8'h01 << $past(convChannel) : 8'h00);
	endproperty
	a_chan: assert property (p_chan) else $error("per trigger");
	property p_per;
		perChannelDmaTrigger != 8'h00 |-> anyChannelDmaTrigger;
	endproperty
	a_per: assert property (p_per) else $error("any trigger");
	property p_irq;
		extraDoneIrq |-> !anyChannelDmaTrigger && perChannelDmaTrigger == 8'h00;
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq with dma");
	property p_was; done |-> $past(convActive); endproperty
	a_was: assert property (p_was)
		else $error("done when idle");
	property p_end; $fell(convActive) |-> done; endproperty
	a_end: assert property (p_end)
		else $error("end without done");
	property p_hold;
		convActive && $past(convActive) && !done |->
			$stable(convChannel) && $stable(convDecimation);
	endproperty
	a_hold: assert property (p_hold)
		else $error("settings moved");
	c_irq: cover property (extraDoneIrq);
	c_ch1: cover property (perChannelDmaTrigger[1]);
	c_end: cover property ($fell(convActive));
endmodule
bind adcseq_top adcseq_chk u_chk (
	.clk, .srst, .convTick, .convActive, .convChannel, .convDecimation,
	.extraDoneIrq, .perChannelDmaTrigger, .anyChannelDmaTrigger
);

// File: sim/adcseq_core_model.sv
// analog core stand-in returning a channel-tagged result
`timescale 1ns/100ps
`include "adcseq_regs.svh"
module adcseq_core_model (
	input wire logic                  clk,
	input wire logic                  convActive,
	input wire logic [3:0]            convChannel,
	output logic [`ADCSEQ_RES_W-1:0]  convResult
);
	initial convResult = 14'h0000;
	// negative code so sign bits show; churns when idle
	always @(posedge clk) begin
		if (convActive) begin
			convResult <= {2'h2, convChannel, 8'h5A};
		end else begin
			convResult <= ~convResult;
		end
	end
endmodule

// File: sim/tb_adcseq_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`include "adcseq_regs.svh"
module tb_adcseq_top;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic externalTriggerPin = 1'h0, timerCompareEvent = 1'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, convReference, convDecimation;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, convTick, convActive, extraDoneIrq;
	logic anyChannelDmaTrigger;
	logic [3:0] convChannel;
	logic [7:0] perChannelDmaTrigger, perSeen = 8'h00;
	logic [13:0] convResult;
	int numErrors = 0, nTests = 0, nDma = 0, nIrq = 0;

	always #2.5 clk = ~clk;

	adcseq_top u_dut (
		.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .externalTriggerPin,
		.timerCompareEvent, .convResult, .convTick, .convActive,
		.convChannel, .convReference, .convDecimation, .extraDoneIrq,
		.perChannelDmaTrigger, .anyChannelDmaTrigger
	);
	adcseq_core_model u_core (.clk, .convActive, .convChannel, .convResult);

	always @(posedge clk) begin
		if (anyChannelDmaTrigger === 1'h1) nDma++;
		if (extraDoneIrq === 1'h1) nIrq++;
		perSeen = perSeen | perChannelDmaTrigger;
	end

	task automatic chk(input string n, input logic [31:0] got, exp);
		nTests++;
		if (got !== exp) begin
			numErrors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic giveVerdict;
		if (numErrors == 0 && nTests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic axiWr(input logic [7:0] idx, d,
			input logic [1:0] er = `ADCSEQ_RESP_OKAY);
		s_axi_awaddr  <= {idx, 2'h0};
		s_axi_wdata   <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_awvalid | s_axi_wvalid);
		while (s_axi_bvalid !== 1'h1) @(posedge clk);
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input string n, input logic [7:0] idx, exp,
			input logic [1:0] er = `ADCSEQ_RESP_OKAY);
		s_axi_araddr  <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do @(posedge clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (s_axi_rvalid !== 1'h1);
		chk(n, s_axi_rdata, {24'h000000, exp});
		chk(n, {30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	// a start lands with the write answer or one cycle after it;
	// the last edge lets the trigger counters take the final pulse
	task automatic waitIdle;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 40000 && convActive; i++) @(posedge clk);
		chk("idle", convActive, 1'h0);
		@(posedge clk);
	endtask

	task automatic tReset;
		logic [7:0] idx [6] = '{8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hBA, 8'h00};
		logic [7:0] exp [6] = '{8'h33, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd("reset", idx[i], exp[i], i == 5 ? 2'h2 : 2'h0);
		end
		axiWr(8'h00, 8'h55, `ADCSEQ_RESP_SLVERR);
	endtask

	task automatic tSeq;
		logic [13:0] e;
		int d0;
		e = {2'h2, 4'h1, 8'h5A};
		axiWr(`ADCSEQ_IDX_AINEN, 8'h03);
		// rate 128 here so the length check sees a second code
		axiWr(`ADCSEQ_IDX_SEQ, 8'h11);
		d0 = nDma;
		perSeen = 8'h00;
		axiWr(`ADCSEQ_IDX_CTRL, 8'h73);
		rd("running", `ADCSEQ_IDX_CTRL, 8'h73);
		axiWr(`ADCSEQ_IDX_CTRL, 8'h73);
		waitIdle();
		chk("seq count", nDma - d0, 2);
		chk("per trig", perSeen, 8'h03);
		rd("eoc set", `ADCSEQ_IDX_CTRL, 8'hB3);
		rd("res chan", `ADCSEQ_IDX_SEQ, 8'h11);
		rd("low byte", `ADCSEQ_IDX_RESLO, {e[5:0], 2'h0});
		rd("high byte", `ADCSEQ_IDX_RESHI, e[13:6]);
		rd("eoc clear", `ADCSEQ_IDX_CTRL, 8'h33);
		chk("no requeue", convActive, 1'h0);
	endtask

	task automatic tExtra;
		int d0, i0;
		d0 = nDma;
		i0 = nIrq;
		// rate 256 on this extra
		axiWr(`ADCSEQ_IDX_EXTRA, 8'hAC);
		repeat (4) @(posedge clk);
		chk("extra cfg", {convActive, convReference, convDecimation,
			convChannel}, 9'h1AC);
		waitIdle();
		// high byte of the model's {10, channel, 5A} result
		rd("extra hi", `ADCSEQ_IDX_RESHI, {2'h2, 4'hC, 2'h1});
		axiWr(`ADCSEQ_IDX_SEQ, 8'h00);
		axiWr(`ADCSEQ_IDX_CTRL, 8'h73);
		axiWr(`ADCSEQ_IDX_EXTRA, 8'h8C);
		chk("seq first", convChannel, 4'h0);
		waitIdle();
		waitIdle();
		chk("irq count", nIrq - i0, 2);
		chk("dma count", nDma - d0, 1);
		rd("last chan", `ADCSEQ_IDX_SEQ, 8'h0C);
	endtask

	task automatic tSources;
		int d0;
		axiWr(`ADCSEQ_IDX_CTRL, 8'h03);
		axiWr(`ADCSEQ_IDX_CTRL, 8'h43);
		repeat (20) @(posedge clk);
		chk("st other src", convActive, 1'h0);
		d0 = nDma;
		externalTriggerPin <= 1'h1;
		waitIdle();
		externalTriggerPin <= 1'h0;
		axiWr(`ADCSEQ_IDX_CTRL, 8'h23);
		timerCompareEvent <= 1'h1;
		@(posedge clk);
		timerCompareEvent <= 1'h0;
		waitIdle();
		chk("ext and timer", nDma - d0, 2);
		axiWr(`ADCSEQ_IDX_CTRL, 8'h13);
		for (int i = 0; i < 20000 && nDma - d0 < 4; i++) @(posedge clk);
		chk("full speed", nDma - d0, 4);
		axiWr(`ADCSEQ_IDX_CTRL, 8'h33);
		waitIdle();
	endtask

	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		tReset();
		tSeq();
		tExtra();
		tSources();
		giveVerdict();
	end

	initial begin
		#500000;
		numErrors++;
		giveVerdict();
	end
endmodule
